// ---- src/agps_sequencer.sv ----
// Gate phase sequencer for one half-bridge driven by a PWM input.
// Assumes comparator and PWM inputs are asynchronous pins and all
// configuration inputs are quasi-static levels on i_clock.
`timescale 1ns/1ns
module agps_sequencer
   import agps_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_srst,
   // Pins from the bridge
   input  wire logic       i_pwm_input,
   input  wire logic       i_node_above_high,
   input  wire logic       i_node_below_low,
   // Configuration
   input  wire logic       i_halfbridge_pwm_enable,
   input  wire logic       i_active_freewheel_en,
   input  wire logic       i_lowside_pwm,
   input  wire logic [1:0] i_adaptive_gate_mode,
   input  wire logic       i_adaptation_filter_sel,
   input  wire logic       i_adaptation_step_sel,
   input  wire agps_code_t i_charge_current,
   input  wire agps_code_t i_discharge_current,
   input  wire agps_code_t i_freewheel_current,
   input  wire agps_code_t i_max_current_limit,
   input  wire agps_code_t i_precharge_init,
   input  wire agps_code_t i_predischarge_init,
   input  wire agps_time_t i_fw_ccp_time,
   input  wire agps_time_t i_active_ccp_time,
   input  wire agps_time_t i_precharge_duration,
   input  wire agps_time_t i_predischarge_duration,
   input  wire agps_time_t i_vds_filter_time,
   input  wire agps_time_t i_turn_on_delay_cfg,
   input  wire agps_time_t i_turn_off_delay_cfg,
   // Gate drive commands
   output agps_drv_e       o_hs_drive,
   output agps_code_t      o_hs_code,
   output agps_drv_e       o_ls_drive,
   output agps_code_t      o_ls_code,
   // Status
   output agps_time_t      o_turn_on_delay,
   output agps_time_t      o_turn_off_delay,
   output agps_code_t      o_precharge_current,
   output agps_code_t      o_predischarge_current
);

   //==========================================================
   // Input synchronisation and edges
   logic [SYNC_W-1:0] sync_lvl;
   logic              pwm_d_r;
   logic              en_d_r;
   logic              pwm;
   logic              pwm_rise;
   logic              pwm_fall;
   logic              en_rise;
   logic              on_done;
   logic              off_done;

   agps_sync u_sync (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .i_async ({i_node_below_low, i_node_above_high, i_pwm_input}),
      .o_level (sync_lvl)
   );

   assign pwm      = sync_lvl[SYNC_PWM];
   assign pwm_rise = pwm && !pwm_d_r;
   assign pwm_fall = !pwm && pwm_d_r;
   assign en_rise  = i_halfbridge_pwm_enable && !en_d_r;

   // Thresholds swap with the mapping
   assign on_done  = i_lowside_pwm ? sync_lvl[SYNC_LOW] : sync_lvl[SYNC_HIGH];
   assign off_done = i_lowside_pwm ? sync_lvl[SYNC_HIGH] : sync_lvl[SYNC_LOW];

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pwm_d_r <= 1'b0;
         en_d_r  <= 1'b0;
      end else begin
         pwm_d_r <= pwm;
         en_d_r  <= i_halfbridge_pwm_enable;
      end
   end

   //==========================================================
   // Phase state machine
   agps_state_e state_r;
   agps_state_e state_nxt;
   agps_time_t  cnt_r;
   agps_time_t  ccp_cnt_r;
   logic        ccp_run_r;
   logic        cnt_done;
   logic [8:0]  cnt_inc;
   logic        ccp_done;
   logic        fw_on;

   assign fw_on    = i_active_freewheel_en;
   assign cnt_inc  = {1'b0, cnt_r} + 9'h001;
   assign ccp_done = !ccp_run_r;

   // Duration of the current phase in whole cycles, never under one
   always_comb begin
      unique case (state_r)
         ST_ON_CCP, ST_OFF_SYM:  cnt_done = cnt_inc >= {1'b0, i_fw_ccp_time};
         ST_PRECHG:              cnt_done = cnt_inc >= {1'b0, i_precharge_duration};
         ST_PREDCHG:             cnt_done = cnt_inc >= {1'b0, i_predischarge_duration};
         ST_POSTCHG, ST_FW_CHG:  cnt_done = cnt_inc >= {1'b0, i_vds_filter_time};
         default:                cnt_done = 1'b0;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE, ST_OFF: begin
            if (pwm_rise || (state_r == ST_IDLE && pwm)) begin
               state_nxt = fw_on ? ST_ON_CCP : ST_PRECHG;
            end
         end
         ST_ON_CCP:  if (cnt_done) state_nxt = ST_PRECHG;
         ST_PRECHG:  if (cnt_done) state_nxt = ST_CHG;
         ST_CHG:     if (on_done) state_nxt = ST_POSTCHG;
         ST_POSTCHG: if (cnt_done) state_nxt = ST_ON;
         ST_ON:      ;
         ST_OFF_SYM: if (cnt_done) state_nxt = ST_PREDCHG;
         ST_PREDCHG: if (cnt_done) state_nxt = ST_DCHG;
         ST_DCHG:    if (ccp_done) state_nxt = fw_on ? ST_FW_CHG : ST_OFF;
         ST_FW_CHG:  if (cnt_done) state_nxt = ST_OFF;
      endcase
      // Falling edge aborts any turn-on phase
      if (pwm_fall && state_r inside {ST_ON_CCP, ST_PRECHG, ST_CHG, ST_POSTCHG, ST_ON}) begin
         state_nxt = fw_on ? ST_OFF_SYM : ST_PREDCHG;
      end
      if (!i_halfbridge_pwm_enable) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Phase timer restarts on every state change
   always_ff @(posedge i_clock) begin
      if (i_srst || state_nxt != state_r) begin
         cnt_r <= TIME_ZERO;
      end else if (cnt_r != TIME_SAT) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // Turn-off cross-current time runs beside pre-discharge and discharge
   always_ff @(posedge i_clock) begin
      if (i_srst || !i_halfbridge_pwm_enable) begin
         ccp_run_r <= 1'b0;
         ccp_cnt_r <= TIME_ZERO;
      end else if (state_nxt == ST_PREDCHG && state_r != ST_PREDCHG) begin
         ccp_run_r <= 1'b1;
         ccp_cnt_r <= TIME_ZERO;
      end else if (ccp_run_r) begin
         ccp_cnt_r <= ccp_cnt_r + 8'h01;
         if ({1'b0, ccp_cnt_r} + 9'h002 >= {1'b0, i_active_ccp_time}) begin
            ccp_run_r <= 1'b0;
         end
      end
   end

   //==========================================================
   // Delay measurement
   agps_time_t on_meas_r;
   agps_time_t off_meas_r;
   agps_time_t on_eff_r;
   agps_time_t off_eff_r;
   logic       off_seen_r;
   logic       on_valid;
   logic       off_valid;

   assign on_valid  = state_r == ST_CHG && on_done;
   assign off_valid = state_r == ST_DCHG && ccp_done;

   always_ff @(posedge i_clock) begin
      if (i_srst || (state_r != ST_PRECHG && state_r != ST_CHG)) begin
         on_meas_r <= TIME_ZERO;
      end else if (on_meas_r != TIME_SAT) begin
         on_meas_r <= on_meas_r + 8'h01;
      end
   end

   // Turn-off delay stops at the far threshold crossing
   always_ff @(posedge i_clock) begin
      if (i_srst || (state_r != ST_PREDCHG && state_r != ST_DCHG)) begin
         off_meas_r <= TIME_ZERO;
         off_seen_r <= 1'b0;
      end else if (off_done) begin
         off_seen_r <= 1'b1;
      end else if (!off_seen_r && off_meas_r != TIME_SAT) begin
         off_meas_r <= off_meas_r + 8'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         on_eff_r  <= TIME_ZERO;
         off_eff_r <= TIME_ZERO;
      end else begin
         if (on_valid) on_eff_r <= on_meas_r;
         if (off_valid) off_eff_r <= off_meas_r;
      end
   end

   //==========================================================
   // Adaptive currents
   agps_adapt_if pre_if ();
   agps_adapt_if pdc_if ();

   assign pre_if.load       = en_rise;
   assign pre_if.init       = i_precharge_init;
   assign pre_if.max_code   = i_max_current_limit;
   assign pre_if.adapt_en   = i_adaptive_gate_mode[1] == MODE_ADAPT[1];
   assign pre_if.filter_sel = i_adaptation_filter_sel;
   assign pre_if.step_sel   = i_adaptation_step_sel;
   assign pre_if.meas_valid = on_valid;
   assign pre_if.meas_slow  = on_meas_r > i_turn_on_delay_cfg;
   assign pre_if.meas_fast  = on_meas_r < i_turn_on_delay_cfg;

   assign pdc_if.load       = en_rise;
   assign pdc_if.init       = i_predischarge_init;
   assign pdc_if.max_code   = i_max_current_limit;
   assign pdc_if.adapt_en   = i_adaptive_gate_mode[1] == MODE_ADAPT[1];
   assign pdc_if.filter_sel = i_adaptation_filter_sel;
   assign pdc_if.step_sel   = i_adaptation_step_sel;
   assign pdc_if.meas_valid = off_valid;
   assign pdc_if.meas_slow  = off_meas_r > i_turn_off_delay_cfg;
   assign pdc_if.meas_fast  = off_meas_r < i_turn_off_delay_cfg;

   agps_adapt u_pre (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .bus     (pre_if.adapt)
   );

   agps_adapt u_pdc (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .bus     (pdc_if.adapt)
   );

   //==========================================================
   // Post-charge ramp
   agps_code_t ramp_r;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ramp_r <= CODE_MIN;
      end else if (state_r != ST_POSTCHG) begin
         ramp_r <= (i_charge_current < i_max_current_limit) ?
                   i_charge_current : i_max_current_limit;
      end else if (ramp_r < i_max_current_limit) begin
         ramp_r <= ramp_r + STEP_ONE;
      end
   end

   //==========================================================
   // Drive per role, then mapped to gates
   agps_drv_e  act_drv;
   agps_code_t act_code;
   agps_drv_e  fw_drv;
   agps_code_t fw_code;
   logic       fw_cond;

   // Freewheel charge only while the node sits past the far threshold
   assign fw_cond = off_done;

   always_comb begin
      act_drv  = DRV_OFF;
      act_code = CODE_MIN;
      fw_drv   = DRV_OFF;
      fw_code  = CODE_MIN;
      unique case (state_r)
         ST_IDLE: ;
         ST_ON_CCP: begin
            fw_drv  = DRV_SNK;
            fw_code = i_freewheel_current;
         end
         ST_PRECHG: begin
            act_drv  = DRV_SRC;
            act_code = pre_if.code;
         end
         ST_CHG: begin
            act_drv  = DRV_SRC;
            act_code = i_charge_current;
         end
         ST_POSTCHG: begin
            act_drv  = DRV_SRC;
            act_code = ramp_r;
         end
         ST_ON, ST_OFF_SYM: act_drv = DRV_ON;
         ST_PREDCHG: begin
            act_drv  = DRV_SNK;
            act_code = pdc_if.code;
         end
         ST_DCHG: begin
            act_drv  = DRV_SNK;
            act_code = i_discharge_current;
         end
         ST_FW_CHG: begin
            fw_drv  = fw_cond ? DRV_SRC : DRV_OFF;
            fw_code = i_freewheel_current;
         end
         ST_OFF: fw_drv = DRV_ON;
      endcase
      if (!fw_on) begin
         fw_drv  = DRV_OFF;
         fw_code = CODE_MIN;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_hs_drive <= DRV_OFF;
         o_hs_code  <= CODE_MIN;
         o_ls_drive <= DRV_OFF;
         o_ls_code  <= CODE_MIN;
      end else if (i_lowside_pwm) begin
         o_hs_drive <= fw_drv;
         o_hs_code  <= fw_code;
         o_ls_drive <= act_drv;
         o_ls_code  <= act_code;
      end else begin
         o_hs_drive <= act_drv;
         o_hs_code  <= act_code;
         o_ls_drive <= fw_drv;
         o_ls_code  <= fw_code;
      end
   end

   assign o_turn_on_delay        = on_eff_r;
   assign o_turn_off_delay       = off_eff_r;
   assign o_precharge_current    = pre_if.code;
   assign o_predischarge_current = pdc_if.code;

endmodule // agps_sequencer

// ---- src/agps_pkg.sv ----
// Constants, types and state codes of the adaptive gate phase sequencer.
// Assumes one 10 MHz clock; all durations arrive as cycle counts.
// Behaviour
// - Active freewheel: rising edge starts freewheel cross-current time
// - Then pre-charge at adaptive current for set duration
// - Then charge current, measure turn-on delay until high
// - Post-charge ramps one step per cycle to limit
// - Adaptation only in adaptive modes (1,0) and (1,1)
// - Pre-charge code clamped between lowest step and limit
// - Enable sets pre-charge code to min(init, limit)
// - Unfiltered: slow raises, fast lowers pre-charge code
// - Adaptation step is one or two codes
// - Filtered: pre-charge changes only after two agreeing cycles
// - Active freewheel: falling edge delays turn-off symmetrically
// - Then pre-discharge at adaptive current for set duration
// - Discharge, measure turn-off delay, end at cross-current expiry
// - Cross-current off, then freewheel charge below low threshold
// - Enable loads, then clamps, pre-discharge code
// - Unfiltered: slow raises, fast lowers pre-discharge code
// - Filtered: pre-discharge changes only after two agreeing cycles
// - Passive freewheel: complementary transistor always off
// - Passive freewheel: skip cross-current intervals at edges
// - Low-side mapping swaps roles and thresholds
package agps_pkg;

   localparam int          CODE_W     = 6;
   localparam int          TIME_W     = 8;
   localparam logic [5:0]  CODE_MIN   = 6'h00;
   localparam logic [5:0]  STEP_ONE   = 6'h01;
   localparam logic [5:0]  STEP_TWO   = 6'h02;
   localparam logic [7:0]  TIME_ZERO  = 8'h00;
   localparam logic [7:0]  TIME_SAT   = 8'hff;
   localparam logic [1:0]  MODE_ADAPT = 2'h2;
   localparam int          SYNC_W     = 3;
   localparam int          SYNC_PWM   = 0;
   localparam int          SYNC_HIGH  = 1;
   localparam int          SYNC_LOW   = 2;

   typedef logic [CODE_W-1:0] agps_code_t;
   typedef logic [TIME_W-1:0] agps_time_t;

   typedef enum logic [1:0] {
      DRV_OFF,
      DRV_SRC,
      DRV_SNK,
      DRV_ON
   } agps_drv_e;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ON_CCP,
      ST_PRECHG,
      ST_CHG,
      ST_POSTCHG,
      ST_ON,
      ST_OFF_SYM,
      ST_PREDCHG,
      ST_DCHG,
      ST_FW_CHG,
      ST_OFF
   } agps_state_e;

endpackage

// ---- src/agps_adapt_if.sv ----
// Carrier between the sequencer and one adaptive current register.
// Assumes the sequencer issues at most one measurement per PWM period.
`timescale 1ns/1ns
interface agps_adapt_if;
   import agps_pkg::*;
   logic       load;
   agps_code_t init;
   agps_code_t max_code;
   logic       adapt_en;
   logic       filter_sel;
   logic       step_sel;
   logic       meas_valid;
   logic       meas_slow;
   logic       meas_fast;
   agps_code_t code;

   modport ctrl  (output load, init, max_code, adapt_en, filter_sel, step_sel,
                  meas_valid, meas_slow, meas_fast, input code);
   modport adapt (input load, init, max_code, adapt_en, filter_sel, step_sel,
                  meas_valid, meas_slow, meas_fast, output code);
endinterface

// ---- src/agps_sync.sv ----
// Three-flop input synchroniser with agreement of the last two stages.
// Assumes inputs are asynchronous to i_clock.
`timescale 1ns/1ns
module agps_sync
   import agps_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_srst,
   // Raw and filtered levels
   input  wire logic [SYNC_W-1:0] i_async,
   output logic      [SYNC_W-1:0] o_level
);

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic lvl_r;
         // First stage is read only by the second
         always_ff @(posedge i_clock) begin
            s1_r <= i_async[g];
            s2_r <= s1_r;
            s3_r <= s2_r;
         end
         // A change counts only once two stages agree
         always_ff @(posedge i_clock) begin
            if (i_srst) begin
               lvl_r <= 1'b0;
            end else if (s2_r == s3_r) begin
               lvl_r <= s3_r;
            end
         end
         assign o_level[g] = lvl_r;
      end
   endgenerate

endmodule // agps_sync

// ---- src/agps_adapt.sv ----
// One self-adapting gate current code with load, clamp and filter.
// Assumes meas_valid is a one-cycle pulse, once per PWM period.
`timescale 1ns/1ns
module agps_adapt
   import agps_pkg::*;
(
   // Clock and reset
   input  wire logic   i_clock,
   input  wire logic   i_srst,
   // Control and result
   agps_adapt_if.adapt bus
);

   agps_code_t code_r;
   logic       prev_slow_r;
   logic       prev_fast_r;
   agps_code_t step;
   logic [6:0] up_sum;
   logic       do_up;
   logic       do_dn;
   agps_code_t code_nxt;

   assign step = bus.step_sel ? STEP_TWO : STEP_ONE;

   // Filtered mode needs the previous verdict to agree
   always_comb begin
      if (bus.filter_sel) begin
         do_up = bus.meas_slow && prev_slow_r;
         do_dn = bus.meas_fast && prev_fast_r;
      end else begin
         do_up = bus.meas_slow;
         do_dn = bus.meas_fast;
      end
   end

   assign up_sum = {1'b0, code_r} + {1'b0, step};

   always_comb begin
      code_nxt = code_r;
      if (bus.load) begin
         code_nxt = (bus.init < bus.max_code) ? bus.init : bus.max_code;
      end else if (bus.adapt_en && bus.meas_valid && do_up) begin
         code_nxt = (up_sum > {1'b0, bus.max_code}) ? bus.max_code : up_sum[5:0];
      end else if (bus.adapt_en && bus.meas_valid && do_dn) begin
         code_nxt = (code_r < CODE_MIN + step) ? CODE_MIN : code_r - step;
      end
      // Limit may be lowered by software at any time
      if (code_nxt > bus.max_code) begin
         code_nxt = bus.max_code;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         code_r <= CODE_MIN;
      end else begin
         code_r <= code_nxt;
      end
   end

   // Filter history; a fresh enable forgets old verdicts
   always_ff @(posedge i_clock) begin
      if (i_srst || bus.load) begin
         prev_slow_r <= 1'b0;
         prev_fast_r <= 1'b0;
      end else if (bus.meas_valid) begin
         prev_slow_r <= bus.meas_slow;
         prev_fast_r <= bus.meas_fast;
      end
   end

   assign bus.code = code_r;

endmodule // agps_adapt

// ---- verification/agps_bridge_model.sv ----
// Behavioural half-bridge and switch node for the gate phase sequencer.
// Assumes drive commands from the sequencer; comparator outputs are levels.
`timescale 1ns/1ns
module agps_bridge_model
   import agps_pkg::*;
(
   // Clock
   input  wire logic       i_clock,
   // Gate commands and mapping
   input  wire agps_drv_e  i_hs_drive,
   input  wire agps_drv_e  i_ls_drive,
   input  wire logic       i_lowside_pwm,
   input  wire logic [3:0] i_delay,
   // Comparators
   output logic            o_node_above_high,
   output logic            o_node_below_low
);
   // ==========================================
   // Gate charge of the PWM transistor
   agps_drv_e  act;
   logic [3:0] lvl_r = 4'h0;
   logic       top;
   logic       bot;
   assign act = i_lowside_pwm ? i_ls_drive : i_hs_drive;
   assign top = (lvl_r >= i_delay);
   assign bot = (lvl_r == 4'h0);
   always_ff @(posedge i_clock) begin
      if ((act == DRV_SRC || act == DRV_ON) && !top)
         lvl_r <= lvl_r + 4'h1;
      else if (act != DRV_SRC && act != DRV_ON && !bot)
         lvl_r <= lvl_r - 4'h1;
   end
   // Low-side mapping pulls the node the other way
   assign o_node_above_high = i_lowside_pwm ? bot : top;
   assign o_node_below_low  = i_lowside_pwm ? top : bot;
endmodule // agps_bridge_model

// ---- verification/agps_sequencer_chk.sv ----
// Port checker for the gate phase sequencer.
// Assumes the bench fixes pre-charge to 3 and pre-discharge to 2 cycles.
`timescale 1ns/1ns
module agps_sequencer_chk
   import agps_pkg::*;
(
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_srst,
   // Configuration
   input wire logic       i_halfbridge_pwm_enable,
   input wire logic       i_active_freewheel_en,
   input wire logic       i_lowside_pwm,
   input wire agps_code_t i_charge_current,
   input wire agps_code_t i_discharge_current,
   input wire agps_code_t i_freewheel_current,
   input wire agps_code_t i_max_current_limit,
   input wire agps_code_t i_precharge_init,
   input wire agps_code_t i_predischarge_init,
   // Outputs
   input wire agps_drv_e  o_hs_drive,
   input wire agps_code_t o_hs_code,
   input wire agps_drv_e  o_ls_drive,
   input wire agps_code_t o_ls_code,
   input wire agps_code_t o_precharge_current,
   input wire agps_code_t o_predischarge_current
);
   // ==========================================
   // Role view
   agps_drv_e  act_d;
   agps_drv_e  fw_d;
   agps_code_t act_c;
   agps_code_t fw_c;
   agps_code_t min_pc;
   agps_code_t min_pd;
   logic       pc;
   logic       pd;
   assign act_d  = i_lowside_pwm ? o_ls_drive : o_hs_drive;
   assign fw_d   = i_lowside_pwm ? o_hs_drive : o_ls_drive;
   assign act_c  = i_lowside_pwm ? o_ls_code : o_hs_code;
   assign fw_c   = i_lowside_pwm ? o_hs_code : o_ls_code;
   assign min_pc = (i_precharge_init < i_max_current_limit) ? i_precharge_init
                                                             : i_max_current_limit;
   assign min_pd = (i_predischarge_init < i_max_current_limit) ? i_predischarge_init
                                                               : i_max_current_limit;
   assign pc = (act_d == DRV_SRC) && (act_c == o_precharge_current);
   assign pd = (act_d == DRV_SNK) && (act_c == o_predischarge_current);

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   // ==========================================
   // Assertions
   a_no_overlap: assert property (!(o_hs_drive != DRV_OFF && o_ls_drive != DRV_OFF))
      else $error("both transistors commanded at once");
   a_fw_code: assert property ((fw_d == DRV_SNK || fw_d == DRV_SRC) |-> fw_c == i_freewheel_current)
      else $error("freewheel current code wrong");
   a_pre_clamp: assert property (o_precharge_current <= $past(i_max_current_limit))
      else $error("pre-charge code above limit");
   a_load_pre: assert property ($rose(i_halfbridge_pwm_enable) |=> o_precharge_current == $past(min_pc))
      else $error("pre-charge code not loaded");
   a_load_pd: assert property ($rose(i_halfbridge_pwm_enable) |=> o_predischarge_current == $past(min_pd))
      else $error("pre-discharge code not loaded");
   a_precharge_span: assert property ($rose(act_d == DRV_SRC) |-> pc [*3] ##1 (act_d == DRV_SRC && act_c == i_charge_current))
      else $error("pre-charge span or charge code wrong");
   a_predis_span: assert property (act_d == DRV_SNK && $past(act_d) == DRV_ON |-> pd [*2] ##1 (act_d == DRV_SNK && act_c == i_discharge_current))
      else $error("pre-discharge span or discharge code wrong");
   a_post_ramp: assert property (act_d == DRV_SRC && act_c > i_charge_current && act_c < i_max_current_limit && act_c != o_precharge_current |=> act_d != DRV_SRC || act_c == $past(act_c) + 6'h01)
      else $error("post-charge ramp step wrong");
   a_passive_off: assert property ((!i_active_freewheel_en) [*3] |-> fw_d == DRV_OFF)
      else $error("complementary transistor driven in passive mode");

   c_precharge: cover property ($rose(pc));
   c_predis: cover property ($rose(pd));
   c_fw_charge: cover property (fw_d == DRV_SRC);
endmodule // agps_sequencer_chk

// ---- verification/tb_agps_sequencer.sv ----
// Self-checking bench for the gate phase sequencer with a bridge model.
// Assumes a 10 MHz clock; turn-on/off targets of 0 or 255 force the verdict.
`timescale 1ns/1ns
module tb_agps_sequencer;
   import agps_pkg::*;
   logic        clk, rst, pwm, en, afw, lsm, filt, stp, up_on, up_off;
   logic        above, below, was_on, now_on, hist_on, hist_off;
   logic [1:0]  mode;
   logic [3:0]  dly;
   agps_code_t  chg, dchg, fwc, mx, pci, pdi, exp_pc, exp_pd;
   agps_time_t  tfw, tccp, tpc, tpd, tvds, don, doff, ton_o, toff_o, xoff;
   agps_drv_e   hs_d, ls_d;
   agps_code_t  hs_c, ls_c, pc_o, pd_o;
   logic [27:0] expq[$];
   logic [7:0]  scen [0:7] = '{8'h62, 8'h7d, 8'h27, 8'hf0, 8'haa, 8'h53, 8'h04, 8'hef};
   int          fail_count, tests_run, seed;

   agps_sequencer i_agps_sequencer (.i_clock(clk), .i_srst(rst), .i_pwm_input(pwm),
      .i_node_above_high(above), .i_node_below_low(below), .i_halfbridge_pwm_enable(en),
      .i_active_freewheel_en(afw), .i_lowside_pwm(lsm), .i_adaptive_gate_mode(mode),
      .i_adaptation_filter_sel(filt), .i_adaptation_step_sel(stp), .i_charge_current(chg),
      .i_discharge_current(dchg), .i_freewheel_current(fwc), .i_max_current_limit(mx),
      .i_precharge_init(pci), .i_predischarge_init(pdi), .i_fw_ccp_time(tfw),
      .i_active_ccp_time(tccp), .i_precharge_duration(tpc), .i_predischarge_duration(tpd),
      .i_vds_filter_time(tvds), .i_turn_on_delay_cfg(don), .i_turn_off_delay_cfg(doff),
      .o_hs_drive(hs_d), .o_hs_code(hs_c), .o_ls_drive(ls_d), .o_ls_code(ls_c),
      .o_turn_on_delay(ton_o), .o_turn_off_delay(toff_o), .o_precharge_current(pc_o),
      .o_predischarge_current(pd_o));

   agps_bridge_model i_agps_bridge_model (.i_clock(clk), .i_hs_drive(hs_d),
      .i_ls_drive(ls_d), .i_lowside_pwm(lsm), .i_delay(dly),
      .o_node_above_high(above), .o_node_below_low(below));

   // ==========================================
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask

   task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] s);
      tests_run++;
      if (e !== s) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Saturating step, clamped to the lowest code and the limit
   function automatic agps_code_t adj(agps_code_t c, logic up, logic go);
      logic [6:0] t;
      logic [6:0] s;
      s = stp ? 7'h02 : 7'h01;
      t = {1'b0, c};
      if (go) t = up ? t + s : ((t > s) ? t - s : 7'h00);
      return (t > {1'b0, mx}) ? mx : t[5:0];
   endfunction

   // One PWM period; expectation noted before the turn-on
   task automatic pulse();
      logic go;
      go = mode[1] && (!filt || hist_on);
      exp_pc = adj(exp_pc, up_on, go);
      hist_on = 1'b1;
      dly = 4'h1 + 4'($random(seed) & 3);
      expq.push_back({exp_pc, exp_pd, {4'h0, dly} + 8'h05, xoff});
      pwm = 1'b1;
      tick(70 + ($random(seed) & 15));
      pwm = 1'b0;
      tick(70 + ($random(seed) & 15));
      xoff = (tccp <= {4'h0, dly} + 8'h06) ? tccp - 8'h01 : {4'h0, dly} + 8'h05;
      go = mode[1] && (!filt || hist_off);
      exp_pd = adj(exp_pd, up_off, go);
      hist_off = 1'b1;
   endtask

   // ==========================================
   // Scoreboard on each new turn-on
   always @(negedge clk) begin
      now_on = ((lsm ? ls_d : hs_d) === DRV_ON);
      if (!rst && now_on && !was_on) begin
         if (expq.size() == 0)
            chk("spare turn-on", 28'h0000000, 28'h0000001);
         else
            chk("codes and delays", expq.pop_front(), {pc_o, pd_o, ton_o, toff_o});
      end
      was_on = now_on;
   end

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #(30000 * 100);
      fail_count++;
      wrap_up();
   end

   // ==========================================
   // Main sequence
   initial begin
      {pwm, en, afw, lsm, filt, stp, up_on, up_off, mode, dly} = '0;
      {was_on, now_on, hist_on, hist_off} = '0;
      fail_count = 0;
      tests_run = 0;
      seed = 32'h1ebeeeb9;
      chg = 6'h20;
      mx = 6'h28;
      dchg = 6'h3f;
      {fwc, pci, pdi, exp_pc, exp_pd, don, doff, xoff} = '0;
      tfw = 8'h02;
      tccp = 8'h06;
      tpc = 8'h03;
      tpd = 8'h02;
      tvds = 8'h14;
      rst = 1'b1;
      tick(8);
      rst = 1'b0;
      foreach (scen[k]) begin
         {lsm, afw, mode, filt, stp, up_on, up_off} = scen[k];
         en = 1'b0;
         tfw = 8'h01 + (8'($random(seed)) & 8'h03);
         tccp = 8'h06 + (8'($random(seed)) & 8'h03);
         tvds = 8'h10 + (8'($random(seed)) & 8'h0f);
         fwc = 6'($random(seed));
         pci = up_on ? (6'h20 | 6'($random(seed))) : (6'($random(seed)) & 6'h07);
         pdi = up_off ? (6'h20 | 6'($random(seed))) : (6'($random(seed)) & 6'h07);
         don = up_on ? 8'h00 : 8'hff;
         doff = up_off ? 8'h00 : 8'hff;
         exp_pc = (pci < mx) ? pci : mx;
         exp_pd = (pdi < mx) ? pdi : mx;
         hist_on = 1'b0;
         hist_off = 1'b0;
         tick(4);
         en = 1'b1;
         tick(8);
         repeat (6) pulse();
         tick(150);
         chk("pending turn-ons", 28'h0000000, 28'(expq.size()));
      end
      wrap_up();
   end
endmodule // tb_agps_sequencer
bind agps_sequencer agps_sequencer_chk i_agps_sequencer_chk (.i_clock, .i_srst,
   .i_halfbridge_pwm_enable, .i_active_freewheel_en, .i_lowside_pwm, .i_charge_current,
   .i_discharge_current, .i_freewheel_current, .i_max_current_limit, .i_precharge_init,
   .i_predischarge_init, .o_hs_drive, .o_hs_code, .o_ls_drive, .o_ls_code,
   .o_precharge_current, .o_predischarge_current);
